// *** irdm_top.v ***
// Implementation choices: the register offsets and the plain strobed port.
`timescale 1ns/10ps
`include "irdm_defines.vh"
// Overview of operation
// - Direct mode passes a non-155 MHz selected input to the phase comparator undivided.
// - A direct-mode 155 MHz input is halved before phase comparison.
// - Frequency entry bit 6 makes hardware divide the input down to 8 kHz; the code divides by a fixed 1250.
// - Test control bit 2 picks which input edge the 8 kHz path uses.
// - Manual divide mode divides by N plus one, N from 1 to 15624.
// - Frequency entry bit 7 enables manual divide; N must yield 8 kHz.
// - One shared N register pair serves every manual-divide input.
// - Entry 10XX0000 selects manual divide with 8 kHz after division.
// - Each of three inputs has its own always-running activity monitor.
// - An inactive input is marked invalid and not a selection candidate.
// - Each input has a bucket; a 2-bit id picks one of four sets.
// - Each set holds bucket size, set threshold, clear threshold, decay.
// - Each 128 ms window with an irregularity adds one, saturating at size.
// - Leak is fill rate times 1, 1/2, 1/4 or 1/8.
// - A fill and a leak falling due together apply only the fill.
// - Alarm sets at the set threshold, clears below the clear threshold.
// - Others fail on inactivity; the selected one also on phase or range.
// - When the selected input fails, the best qualified input takes over.
// - A fast loss flag rises after a couple of missing reference cycles; the code waits 512 clocks without a rising edge.
// - Monitor config bit 6 copies the fast loss flag onto TDO.
// - The fast loss flag clears only by a write to interrupt status.
module irdm_top (
    input wire clk,
    input wire rst,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata,
    input wire [2:0] ref_in,
    input wire [2:0] ref_is_155,
    input wire sel_phase_lost,
    input wire sel_out_of_range,
    input wire jtag_tdo,
    output reg tdo_out,
    output reg cmp_ref,
    output reg [1:0] sel_ref,
    output reg [2:0] ref_valid,
    output reg fast_loss
);
////////////////////////////////////////////////////////////////////////////
localparam [23:0] WIN_CYC = `IRDM_WIN_CYC;
localparam [1:0] ST_RUN = 2'b00;
localparam [1:0] ST_SWITCH = 2'b01;

reg [7:0] test1_q;
reg [7:0] moncfg_q;
reg [7:0] selctl_q;
reg [13:0] manual_divide_mode_q;
reg [7:0] freq_q [0:2];
reg [7:0] bkt_q [0:15];
reg [2:0] ref_d1_q;
reg [2:0] ref_d2_q;
reg [2:0] edge_seen_q;
reg [2:0] irreg_q;
reg [23:0] win_cnt_q;
reg [2:0] leak_cnt_q;
reg [7:0] acc_q [0:2];
reg [2:0] alarm_q;
reg [23:0] miss_cnt_q;
reg [1:0] state_q;
reg [13:0] div_cnt_q [0:2];
reg [2:0] div_out_q;
reg [2:0] half_q;
reg [2:0] fail_q;
wire [2:0] cand;
wire win_end;
wire [2:0] rise;
wire [2:0] fall;
wire [2:0] disq;

// The window counter is shared by all inputs, so every bucket fills and
// leaks on the same edge; that lets one leak counter serve all four
// decay settings.
assign win_end = (win_cnt_q == WIN_CYC - 24'h000001);
assign rise = ref_d1_q & ~ref_d2_q;
assign fall = ~ref_d1_q & ref_d2_q;

////////////////////////////////////////////////////////////////////////////
// Register file and read port.
integer k;
always @(posedge clk or posedge rst)
begin
    if (rst)
    begin
        test1_q <= 8'h00;
        moncfg_q <= 8'h00;
        selctl_q <= 8'h00;
        manual_divide_mode_q <= `IRDM_RST_MANUAL_DIVIDE_MODE;
        for (k = 0; k < 3; k = k + 1)
            freq_q[k] <= `IRDM_RST_FREQ;
        for (k = 0; k < 4; k = k + 1)
        begin
            bkt_q[4*k] <= `IRDM_RST_BSIZE;
            bkt_q[4*k+1] <= `IRDM_RST_BSET;
            bkt_q[4*k+2] <= `IRDM_RST_BCLR;
            bkt_q[4*k+3] <= `IRDM_RST_BDECAY;
        end
    end
    else if (reg_wr)
    begin
        // Every byte of a bucket set reads back as written; only the two
        // low bits of the decay entry are used by the leak logic.
        case (reg_addr)
            `IRDM_REG_TEST1: test1_q <= reg_wdata;
            `IRDM_REG_MONCFG: moncfg_q <= reg_wdata;
            `IRDM_REG_SELCTL: selctl_q <= reg_wdata;
            `IRDM_REG_FREQ0: freq_q[0] <= reg_wdata;
            `IRDM_REG_FREQ1: freq_q[1] <= reg_wdata;
            `IRDM_REG_FREQ2: freq_q[2] <= reg_wdata;
            `IRDM_REG_MANUAL_DIVIDE_MODE_LO: manual_divide_mode_q[7:0] <= reg_wdata;
            `IRDM_REG_MANUAL_DIVIDE_MODE_HI: manual_divide_mode_q[13:8] <= reg_wdata[5:0];
            default:
            begin
                if (reg_addr[7:4] == 4'h5)
                    bkt_q[reg_addr[3:0]] <= reg_wdata;
            end
        endcase
    end
end

// Reads return zero outside the cycle after a read strobe, so the read
// bus can be merged with that of other blocks by a plain OR.
always @(posedge clk or posedge rst)
begin
    if (rst)
        reg_rdata <= 8'h00;
    else if (reg_rd)
    begin
        case (reg_addr)
            `IRDM_REG_TEST1: reg_rdata <= test1_q;
            `IRDM_REG_MONCFG: reg_rdata <= moncfg_q;
            `IRDM_REG_SELCTL: reg_rdata <= selctl_q;
            `IRDM_REG_FREQ0: reg_rdata <= freq_q[0];
            `IRDM_REG_FREQ1: reg_rdata <= freq_q[1];
            `IRDM_REG_FREQ2: reg_rdata <= freq_q[2];
            `IRDM_REG_MANUAL_DIVIDE_MODE_LO: reg_rdata <= manual_divide_mode_q[7:0];
            `IRDM_REG_MANUAL_DIVIDE_MODE_HI: reg_rdata <= {2'b00, manual_divide_mode_q[13:8]};
            `IRDM_REG_INTSTS: reg_rdata <= {1'b0, fast_loss, 6'h00};
            `IRDM_REG_VALID: reg_rdata <= {alarm_q, 2'b00, ref_valid};
            default:
            begin
                if (reg_addr[7:4] == 4'h5)
                    reg_rdata <= bkt_q[reg_addr[3:0]];
                else
                    reg_rdata <= 8'h00;
            end
        endcase
    end
    else
        reg_rdata <= 8'h00;
end

////////////////////////////////////////////////////////////////////////////
// Shared window and leak timebase.
always @(posedge clk or posedge rst)
begin
    if (rst)
    begin
        win_cnt_q <= 24'h000000;
        leak_cnt_q <= 3'b000;
        ref_d1_q <= 3'b000;
        ref_d2_q <= 3'b000;
    end
    else
    begin
        // Inputs are taken as synchronous; the two stages serve edge detection,
        // and the first also feeds cmp_ref in direct mode.
        ref_d1_q <= ref_in;
        ref_d2_q <= ref_d1_q;
        if (win_end)
        begin
            win_cnt_q <= 24'h000000;
            leak_cnt_q <= leak_cnt_q + 3'b001;
        end
        else
            win_cnt_q <= win_cnt_q + 24'h000001;
    end
end

////////////////////////////////////////////////////////////////////////////
// Per-input monitor, bucket and pre-divider.
genvar g;
generate
    for (g = 0; g < 3; g = g + 1)
    begin : gen_in
        wire [1:0] bid = freq_q[g][`IRDM_FRQ_BKT_LSB+1:`IRDM_FRQ_BKT_LSB];
        wire [7:0] bsize = bkt_q[{bid, 2'b00}];
        wire [7:0] bset = bkt_q[{bid, 2'b01}];
        wire [7:0] bclr = bkt_q[{bid, 2'b10}];
        wire [1:0] decay = bkt_q[{bid, 2'b11}][1:0];
        // Leak every 1, 2, 4 or 8 windows.
        wire leak_due = win_end &&
            ((decay == 2'd0) || (decay == 2'd1 && leak_cnt_q[0]) ||
             (decay == 2'd2 && leak_cnt_q[1:0] == 2'b11) ||
             (decay == 2'd3 && leak_cnt_q == 3'b111));
        wire fill = win_end && (irreg_q[g] || !edge_seen_q[g]);
        wire use_fall = test1_q[`IRDM_EDGE_BIT];
        wire div_edge = use_fall ? fall[g] : rise[g];
        wire man = freq_q[g][`IRDM_FRQ_MANUAL_DIVIDE_MODE_BIT];
        wire l8k = freq_q[g][`IRDM_FRQ_L8K_BIT];
        // Auto mode uses a fixed factor; exact spot factors need a table.
        wire [13:0] lim = man ? manual_divide_mode_q : `IRDM_L8K_DIV;

        always @(posedge clk or posedge rst)
        begin
            if (rst)
            begin
                edge_seen_q[g] <= 1'b0;
                irreg_q[g] <= 1'b0;
                acc_q[g] <= 8'h00;
                alarm_q[g] <= 1'b0;
                div_cnt_q[g] <= 14'h0000;
                div_out_q[g] <= 1'b0;
                half_q[g] <= 1'b0;
            end
            else
            begin
                // A window without a rising edge counts as irregular.
                if (win_end)
                begin
                    edge_seen_q[g] <= 1'b0;
                    irreg_q[g] <= 1'b0;
                end
                else if (rise[g])
                    edge_seen_q[g] <= 1'b1;
                if (fill)
                begin
                    if (acc_q[g] < bsize)
                        acc_q[g] <= acc_q[g] + 8'h01;
                end
                else if (leak_due && acc_q[g] != 8'h00)
                    acc_q[g] <= acc_q[g] - 8'h01;
                // Between the two thresholds the alarm keeps its state; this
                // hysteresis stops a marginal input from flapping.
                if (acc_q[g] >= bset)
                    alarm_q[g] <= 1'b1;
                else if (acc_q[g] < bclr)
                    alarm_q[g] <= 1'b0;
                if (rise[g])
                    half_q[g] <= ~half_q[g];
                // One pulse per lim plus one input edges keeps the factor
                // exact; the pulse is one clock wide, so the comparator
                // sees one rising edge per division period.
                div_out_q[g] <= 1'b0;
                if ((man || l8k) && div_edge)
                begin
                    if (div_cnt_q[g] >= lim)
                    begin
                        div_cnt_q[g] <= 14'h0000;
                        div_out_q[g] <= 1'b1;
                    end
                    else
                        div_cnt_q[g] <= div_cnt_q[g] + 14'h0001;
                end
            end
        end
    end
endgenerate

////////////////////////////////////////////////////////////////////////////
// Qualification, selection and fast loss.
assign disq = alarm_q;

// An input that failed while selected stays out of the next pick, even
// when its own bucket is still clean; otherwise a phase or range failure
// would hand the selection straight back to the same input.
assign cand = ~disq & ~fail_q;

always @(posedge clk or posedge rst)
begin
    if (rst)
    begin
        ref_valid <= 3'b000;
        sel_ref <= 2'd0;
        state_q <= ST_RUN;
        miss_cnt_q <= 24'h000000;
        fast_loss <= 1'b0;
        tdo_out <= 1'b0;
        cmp_ref <= 1'b0;
        fail_q <= 3'b000;
    end
    else
    begin
        ref_valid <= ~disq;
        // The fast detector counts idle clocks on the selected input. It
        // saturates rather than wraps, so a dead input raises the flag once
        // and a software clear holds until the input has failed again.
        if (rise[sel_ref])
            miss_cnt_q <= 24'h000000;
        else if (miss_cnt_q != `IRDM_MISS_CYC)
            miss_cnt_q <= miss_cnt_q + 24'h000001;
        if (miss_cnt_q == `IRDM_MISS_CYC - 24'h000001)
            fast_loss <= 1'b1;
        else if (reg_wr && reg_addr == `IRDM_REG_INTSTS &&
                 reg_wdata[`IRDM_LOSS_BIT])
            fast_loss <= 1'b0;
        if (moncfg_q[`IRDM_TDO_EN_BIT])
            tdo_out <= fast_loss;
        else
            tdo_out <= jtag_tdo;
        if (freq_q[sel_ref][`IRDM_FRQ_MANUAL_DIVIDE_MODE_BIT] ||
            freq_q[sel_ref][`IRDM_FRQ_L8K_BIT])
            cmp_ref <= div_out_q[sel_ref];
        else if (ref_is_155[sel_ref])
            cmp_ref <= half_q[sel_ref];
        else
            cmp_ref <= ref_d1_q[sel_ref];
        case (state_q)
            ST_RUN:
            begin
                if (disq[sel_ref] || sel_phase_lost || sel_out_of_range)
                begin
                    state_q <= ST_SWITCH;
                    fail_q <= 3'b001 << sel_ref;
                end
            end
            ST_SWITCH:
            begin
                // Lowest index is highest priority here. With no candidate
                // left the present input is kept, as holdover is handled
                // outside this block.
                if (cand[0])
                    sel_ref <= 2'd0;
                else if (cand[1])
                    sel_ref <= 2'd1;
                else if (cand[2])
                    sel_ref <= 2'd2;
                state_q <= ST_RUN;
            end
            default: state_q <= ST_RUN;
        endcase
    end
end
endmodule // irdm_top

// *** irdm_defines.vh ***
`ifndef IRDM_DEFINES_VH
`define IRDM_DEFINES_VH
// Register indices (byte-wide registers, one per address).
`define IRDM_REG_TEST1 8'h03
`define IRDM_REG_INTSTS 8'h06
`define IRDM_REG_FREQ0 8'h22
`define IRDM_REG_FREQ1 8'h23
`define IRDM_REG_FREQ2 8'h24
`define IRDM_REG_MANUAL_DIVIDE_MODE_LO 8'h46
`define IRDM_REG_MANUAL_DIVIDE_MODE_HI 8'h47
`define IRDM_REG_MONCFG 8'h48
`define IRDM_REG_BKT_BASE 8'h50
`define IRDM_REG_BKT_LAST 8'h5F
`define IRDM_REG_VALID 8'h0E
`define IRDM_REG_SELCTL 8'h30
// Field positions.
`define IRDM_FRQ_MANUAL_DIVIDE_MODE_BIT 7
`define IRDM_FRQ_L8K_BIT 6
`define IRDM_FRQ_BKT_LSB 4
`define IRDM_EDGE_BIT 2
`define IRDM_TDO_EN_BIT 6
`define IRDM_LOSS_BIT 6
// Reset values.
`define IRDM_RST_FREQ 8'h00
`define IRDM_RST_MANUAL_DIVIDE_MODE 14'h0000
`define IRDM_RST_BSIZE 8'h08
`define IRDM_RST_BSET 8'h06
`define IRDM_RST_BCLR 8'h04
`define IRDM_RST_BDECAY 8'h01
// Timing: 10 MHz clock.
`define IRDM_CLK_HZ 10000000
`define IRDM_WIN_MS 128
`define IRDM_WIN_CYC 24'h138800
`define IRDM_MISS_CYC 24'h000200
`define IRDM_MANUAL_DIVIDE_MODE_MAX 14'h3D08
`define IRDM_L8K_DIV 14'h04E1
`endif

// *** irdm_ref_gen.sv ***
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////
// Backplane reference clocks: input n toggles every 2^(n+1) cycles.
module irdm_ref_gen (
    input wire clk,
    input wire rst,
    input wire [2:0] run,
    output reg [2:0] ref_out
);
    reg [3:0] t_q;
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            t_q <= 4'h0;
            ref_out <= 3'h0;
        end
        else
        begin
            t_q <= t_q + 4'h1;
            // A dead line freezes at its last level, like a lost card.
            ref_out <= (t_q[3:1] & run) | (ref_out & ~run);
        end
    end
endmodule // irdm_ref_gen

// *** irdm_checker_assertions.sv ***
`timescale 1ns/10ps
module irdm_checker (
    input wire clk,
    input wire rst,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_rdata,
    input wire [2:0] ref_in,
    input wire jtag_tdo,
    input wire tdo_out,
    input wire [1:0] sel_ref,
    input wire fast_loss
);
    reg mon_q;
    reg last_q;
    reg [9:0] idle_q;
    ////////////////////////////////////////////////////////////////////////
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            mon_q <= 1'b0;
            last_q <= 1'b0;
            idle_q <= 10'h000;
        end
        else
        begin
            if (reg_wr && reg_addr == 8'h48)
                mon_q <= reg_wdata[6];
            last_q <= ref_in[sel_ref];
            if (ref_in[sel_ref] != last_q)
                idle_q <= 10'h000;
            else if (idle_q != 10'h3FF)
                idle_q <= idle_q + 10'h001;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence rd_status_s;
        reg_rd && reg_addr == 8'h06;
    endsequence
    sequence tdo_on_s;
        mon_q [*2];
    endsequence
    tdo_copy_a: assert property (tdo_on_s ##0 $stable(fast_loss)
        |-> tdo_out == fast_loss) else $error("tdo copy wrong");
    tdo_pass_a: assert property (!mon_q [*2] ##0 $stable(jtag_tdo)
        |-> tdo_out == jtag_tdo) else $error("tdo pass wrong");
    loss_rise_a: assert property ($rose(fast_loss)
        |-> idle_q >= 10'd500) else $error("loss flag early");
    loss_bound_a: assert property (idle_q > 10'd530
        |-> fast_loss) else $error("loss flag late");
    loss_hold_a: assert property ($fell(fast_loss)
        |-> $past(reg_wr && reg_addr == 8'h06)) else $error("loss cleared");
    rd_status_a: assert property (rd_status_s
        |=> reg_rdata == {1'b0, $past(fast_loss), 6'h00})
        else $error("status read wrong");
    rd_idle_a: assert property (!reg_rd |=> reg_rdata == 8'h00)
        else $error("read data not idle");
    rd_unmap_a: assert property (reg_rd && reg_addr == 8'hFF
        |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
endmodule // irdm_checker
bind irdm_top irdm_checker i_chk (.clk, .rst, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .ref_in, .jtag_tdo, .tdo_out, .sel_ref,
    .fast_loss);

// *** testbench.sv ***
`timescale 1ns/10ps
`define CHK(g, e) begin compares = compares + 1; if ((g) !== (e)) begin \
    n_fail = n_fail + 1; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module testbench;
    reg clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    reg [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, r, a, d;
    reg [2:0] ref_is_155 = 3'h0, run = 3'h7;
    reg sel_phase_lost = 1'b0, jtag_tdo = 1'b0;
    wire [7:0] reg_rdata;
    wire [2:0] ref_in, ref_valid;
    wire tdo_out, cmp_ref, fast_loss;
    wire [1:0] sel_ref;
    integer n_fail = 0, compares = 0, cyc = 0, seed = 95, i, m, cr, rr, ex;
    reg [7:0] mdl [0:255];
    reg [1:0] pc;
    always #50 clk = ~clk;
    irdm_ref_gen i_ref (.clk(clk), .rst(rst), .run(run), .ref_out(ref_in));
    irdm_top i_dut (.clk(clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .ref_in(ref_in), .ref_is_155(ref_is_155),
        .sel_phase_lost(sel_phase_lost), .sel_out_of_range(1'b0),
        .jtag_tdo(jtag_tdo), .tdo_out(tdo_out), .cmp_ref(cmp_ref),
        .sel_ref(sel_ref), .ref_valid(ref_valid), .fast_loss(fast_loss));
    ////////////////////////////////////////////////////////////////////////
    task wr(input [7:0] wa, input [7:0] wd);
    begin
        reg_addr <= wa;
        reg_wdata <= wd;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        @(posedge clk);
    end
    endtask
    task rd(input [7:0] ra);
    begin
        reg_addr <= ra;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 r = reg_rdata;
        @(posedge clk);
    end
    endtask
    function [7:0] ad(input integer k);
        ad = k < 16 ? 8'h50 + k[7:0] : k < 19 ? 8'h12 + k[7:0] :
            k == 19 ? 8'h46 : k == 20 ? 8'h47 : 8'hFF;
    endfunction
    task end_of_test;
    begin
        $display("compares=%0d n_fail=%0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    end
    endtask
    always @(posedge clk)
    begin
        cyc = cyc + 1;
        if (cyc == 6000)
        begin
            n_fail = n_fail + 1;
            end_of_test;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        for (i = 0; i < 256; i = i + 1)
            mdl[i] = 8'h00;
        for (i = 0; i < 16; i = i + 1)
            mdl[8'h50 + i] = i % 4 == 0 ? 8'h08 : i % 4 == 1 ? 8'h06 :
                i % 4 == 2 ? 8'h04 : 8'h01;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        for (m = 0; m < 22; m = m + 1)
        begin
            rd(ad(m));
            `CHK(r, mdl[ad(m)])
        end
        repeat (24)
        begin
            a = ad({$random(seed)} % 22);
            d = $random(seed);
            // Auto 8 kHz stays off: the bench clocks are not spot rates.
            if (a < 8'h25)
                d = d & 8'hB0;
            // A zero set threshold would raise the alarm of every input using that set at once.
            if (a[7:4] == 4'h5 && a[1:0] == 2'h1 && d == 8'h00)
                d = 8'h01;
            wr(a, d);
            mdl[a] = a == 8'hFF ? 8'h00 : a == 8'h47 ? d & 8'h3F : d;
            rd(a);
            `CHK(r, mdl[a])
        end
        $display("test registers done");
        wr(8'h46, 8'h03);
        wr(8'h47, 8'h00);
        for (m = 0; m < 3; m = m + 1)
        begin
            ref_is_155 <= {2'h0, m == 1};
            wr(8'h22, m == 2 ? 8'h80 : 8'h00);
            repeat (20) @(posedge clk);
            cr = 0;
            rr = 0;
            pc = 2'h3;
            repeat (400) @(negedge clk)
            begin
                cr = cr + (cmp_ref && !pc[0]);
                rr = rr + (ref_in[0] && !pc[1]);
                pc = {ref_in[0], cmp_ref};
            end
            @(posedge clk);
            ex = rr / (m == 0 ? 1 : m == 1 ? 2 : 4);
            `CHK(cr >= ex - 1 && cr <= ex + 1, 1'b1)
        end
        wr(8'h22, 8'h00);
        ref_is_155 <= 3'h0;
        $display("test divider done");
        run <= 3'h6;
        repeat (600) @(posedge clk);
        #1 `CHK(fast_loss, 1'b1)
        wr(8'h48, 8'h40);
        rd(8'h06);
        `CHK(r, 8'h40)
        repeat (3) @(posedge clk);
        #1 `CHK(tdo_out, 1'b1)
        run <= 3'h7;
        repeat (20) @(posedge clk);
        #1 `CHK(fast_loss, 1'b1)
        wr(8'h06, 8'h40);
        #1 `CHK(fast_loss, 1'b0)
        d = $random(seed);
        jtag_tdo <= d[0];
        wr(8'h48, 8'h00);
        repeat (3) @(posedge clk);
        #1 `CHK(tdo_out, jtag_tdo)
        $display("test fast loss done");
        `CHK(ref_valid, 3'h7)
        sel_phase_lost <= 1'b1;
        @(posedge clk);
        sel_phase_lost <= 1'b0;
        repeat (3) @(posedge clk);
        #1 `CHK(sel_ref, 2'h1)
        $display("test selection done");
        end_of_test;
    end
endmodule // testbench
